/* File: hdl/lock_detect_pkg.sv */
// Purpose: Constants and types for the dual-channel lock detector block.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses.
// Notes: Levels are 12-bit two's complement, -2048 empty, +2047 full.
package lock_detect_pkg;
    localparam int NPROF = 8;
    localparam int ADDR_W = 16;
    localparam logic signed [11:0] LV_EMPTY = 12'sh800;
    localparam logic signed [11:0] LV_FULL = 12'sh7FF;
    localparam logic signed [11:0] LV_LOW = 12'shBFF;
    localparam logic signed [11:0] LV_HIGH = 12'sh400;
    // Register map.
    localparam logic [15:0] PROF_BASE = 16'h0100;
    localparam logic [1:0] OFS_PTHR = 2'h0;
    localparam logic [1:0] OFS_PRATE = 2'h1;
    localparam logic [1:0] OFS_FTHR = 2'h2;
    localparam logic [1:0] OFS_FRATE = 2'h3;
    localparam logic [15:0] CH0_BASE = 16'h3100;
    localparam logic [15:0] CH1_BASE = 16'h3200;
    localparam logic [7:0] CH_STATUS = 8'h00;
    localparam logic [7:0] CH_CLEAR = 8'h04;
    localparam logic [7:0] CH_MASK = 8'h08;
    localparam logic [7:0] CH_CTRL = 8'h0C;
    localparam logic [7:0] CH_LEVEL = 8'h10;
    // Latched bit positions; live lock bits follow at 4 and 5.
    localparam int ST_PLOCK = 0;
    localparam int ST_PUNLOCK = 1;
    localparam int ST_FLOCK = 2;
    localparam int ST_FUNLOCK = 3;
    // Reset values and response codes.
    localparam logic [23:0] THR_RST = 24'h000000;
    localparam logic [7:0] FILL_RST = 8'h01;
    localparam logic [7:0] DRAIN_RST = 8'h01;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [2:0] PROF_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [23:0] pthr;
        logic [7:0] pdrain;
        logic [7:0] pfill;
        logic [23:0] fthr;
        logic [7:0] fdrain;
        logic [7:0] ffill;
    } profile_t;

    typedef struct packed {
        logic pd_valid;
        logic signed [31:0] pd_error;
        logic fd_valid;
        logic [31:0] ref_period;
        logic [31:0] fb_period;
        logic slew_limiting;
        logic holdover;
    } loop_in_t;

    typedef struct packed {
        logic signed [11:0] level;
        logic locked;
    } det_t;

    typedef struct packed {
        det_t ph;
        det_t fr;
        logic [3:0] latch;
        logic [3:0] mask;
        logic [2:0] prof;
    } chan_t;

    typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_t;
    typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_t;
endpackage : lock_detect_pkg

/* File: hdl/dpll_lock_detector.sv */
// Purpose: Phase and frequency lock detectors for two loop channels.
// Assumes: Loop inputs come from logic on core_clk, so no synchronisers.
// Notes: All state lives in one struct; core_en low freezes it.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
module dpll_lock_detector
    import lock_detect_pkg::*;
(
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic core_en,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Loop channels
    input wire loop_in_t [1:0] loop_in,
    output logic [1:0] phase_locked,
    output logic [1:0] freq_locked,
    output logic [1:0] irq_pending
);
    typedef struct packed {
        profile_t [NPROF-1:0] prof;
        chan_t [1:0] ch;
        logic [1:0] irq;
        wr_state_t wst;
        rd_state_t rst;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] ph_pass;
    logic [1:0] ph_restart;

    // =========================================================
    // Helpers
    function automatic logic [31:0] merge(logic [31:0] old,
        logic [31:0] din, logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = din[8*b +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] mag(logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    function automatic logic [31:0] prof_word(profile_t pr, logic [1:0] ofs);
        if (ofs == OFS_PTHR)
            return {8'h00, pr.pthr};
        else if (ofs == OFS_PRATE)
            return {16'h0000, pr.pdrain, pr.pfill};
        else if (ofs == OFS_FTHR)
            return {8'h00, pr.fthr};
        else
            return {16'h0000, pr.fdrain, pr.ffill};
    endfunction : prof_word

    function automatic det_t det_step(det_t d, logic pass,
        logic no_fill, logic [7:0] fill, logic [7:0] drain);
        det_t r;
        logic up;
        logic signed [13:0] sum;
        r = d;
        up = (fill != 8'h00) && ((drain == 8'h00) || pass);
        up = up && !no_fill;
        sum = up ? 14'(d.level) + 14'(fill) : 14'(d.level) - 14'(drain);
        if (sum > LV_FULL)
            r.level = LV_FULL;
        else if (sum < LV_EMPTY)
            r.level = LV_EMPTY;
        else
            r.level = sum[11:0];
        if (r.level > LV_HIGH)
            r.locked = 1'b1;
        else if (r.level < LV_LOW)
            r.locked = 1'b0;
        return r;
    endfunction : det_step

    // =========================================================
    // Next state
    always_comb
    begin
        logic a_ok;
        logic w_ok;
        logic [ADDR_W-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [1:0] wresp;
        logic [3:0] clr [2];
        logic [31:0] rd;
        logic [31:0] m;
        logic [1:0] rr;
        logic c;
        logic [2:0] p;
        logic [31:0] fdiff;
        logic prof_chg;
        logic [3:0] set;
        profile_t pr;
        a_ok = s.aw_got | (s.awready & s_axi_awvalid);
        w_ok = s.w_got | (s.wready & s_axi_wvalid);
        wa = s.aw_got ? s.waddr : s_axi_awaddr;
        wd = s.w_got ? s.wdata : s_axi_wdata;
        ws = s.w_got ? s.wstrb : s_axi_wstrb;
        wresp = RESP_OKAY;
        clr[0] = 4'h0;
        clr[1] = 4'h0;
        rd = 32'h00000000;
        m = 32'h00000000;
        rr = RESP_OKAY;
        c = 1'b0;
        p = 3'h0;
        fdiff = 32'h00000000;
        prof_chg = 1'b0;
        set = 4'h0;
        pr = s.prof[0];
        ph_pass = 2'b00;
        ph_restart = 2'b00;
        next_s = s;

        // Write channel.
        case (s.wst)
            W_IDLE:
            begin
                if (a_ok && w_ok)
                begin
                    p = wa[6:4];
                    c = (wa[15:8] == CH1_BASE[15:8]);
                    if (wa[15:7] == PROF_BASE[15:7])
                    begin
                        m = merge(prof_word(s.prof[p], wa[3:2]), wd, ws);
                        if (wa[3:2] == OFS_PTHR)
                            next_s.prof[p].pthr = m[23:0];
                        else if (wa[3:2] == OFS_PRATE)
                            {next_s.prof[p].pdrain, next_s.prof[p].pfill} =
                                m[15:0];
                        else if (wa[3:2] == OFS_FTHR)
                            next_s.prof[p].fthr = m[23:0];
                        else
                            {next_s.prof[p].fdrain, next_s.prof[p].ffill} =
                                m[15:0];
                    end
                    else if (wa[15:8] == CH0_BASE[15:8] ||
                        wa[15:8] == CH1_BASE[15:8])
                    begin
                        if (wa[7:0] == CH_CLEAR)
                            clr[c] = ws[0] ? wd[3:0] : 4'h0;
                        else if (wa[7:0] == CH_MASK && ws[0])
                            next_s.ch[c].mask = wd[3:0];
                        else if (wa[7:0] == CH_CTRL && ws[0])
                            next_s.ch[c].prof = wd[2:0];
                        else if (wa[7:0] != CH_STATUS &&
                            wa[7:0] != CH_LEVEL && wa[7:0] != CH_MASK &&
                            wa[7:0] != CH_CTRL)
                            wresp = RESP_SLVERR;
                    end
                    else
                        wresp = RESP_SLVERR;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    next_s.awready = 1'b0;
                    next_s.wready = 1'b0;
                    next_s.bvalid = 1'b1;
                    next_s.bresp = wresp;
                    next_s.wst = W_RESP;
                end
                else
                begin
                    next_s.aw_got = a_ok;
                    next_s.w_got = w_ok;
                    next_s.waddr = wa;
                    next_s.wdata = wd;
                    next_s.wstrb = ws;
                    next_s.awready = !a_ok;
                    next_s.wready = !w_ok;
                end
            end
            W_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_s.bvalid = 1'b0;
                    next_s.awready = 1'b1;
                    next_s.wready = 1'b1;
                    next_s.wst = W_IDLE;
                end
            end
            default:
                next_s.wst = W_IDLE;
        endcase

        // Read channel.
        p = s_axi_araddr[6:4];
        c = (s_axi_araddr[15:8] == CH1_BASE[15:8]);
        if (s_axi_araddr[15:7] == PROF_BASE[15:7])
        begin
            rd = prof_word(s.prof[p], s_axi_araddr[3:2]);
        end
        else if (s_axi_araddr[15:8] == CH0_BASE[15:8] ||
            s_axi_araddr[15:8] == CH1_BASE[15:8])
        begin
            if (s_axi_araddr[7:0] == CH_STATUS)
                rd = {26'h0000000, s.ch[c].fr.locked, s.ch[c].ph.locked,
                    s.ch[c].latch};
            else if (s_axi_araddr[7:0] == CH_CLEAR)
                rd = 32'h00000000;
            else if (s_axi_araddr[7:0] == CH_MASK)
                rd = {28'h0000000, s.ch[c].mask};
            else if (s_axi_araddr[7:0] == CH_CTRL)
                rd = {29'h00000000, s.ch[c].prof};
            else if (s_axi_araddr[7:0] == CH_LEVEL)
                rd = {4'h0, s.ch[c].fr.level, 4'h0, s.ch[c].ph.level};
            else
                rr = RESP_SLVERR;
        end
        else
            rr = RESP_SLVERR;
        case (s.rst)
            R_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    next_s.rdata = rd;
                    next_s.rresp = rr;
                    next_s.rvalid = 1'b1;
                    next_s.arready = 1'b0;
                    next_s.rst = R_DATA;
                end
            end
            R_DATA:
            begin
                if (s_axi_rready)
                begin
                    next_s.rvalid = 1'b0;
                    next_s.arready = 1'b1;
                    next_s.rst = R_IDLE;
                end
            end
            default:
                next_s.rst = R_IDLE;
        endcase

        // Detectors.
        for (int k = 0; k < 2; k++)
        begin
            pr = s.prof[s.ch[k].prof];
            prof_chg = next_s.ch[k].prof != s.ch[k].prof;
            ph_pass[k] = mag(loop_in[k].pd_error) <= {8'h00, pr.pthr};
            ph_restart[k] = prof_chg | loop_in[k].holdover;
            if (ph_restart[k])
                next_s.ch[k].ph = '{level: LV_EMPTY, locked: 1'b0};
            else if (loop_in[k].pd_valid)
                next_s.ch[k].ph = det_step(s.ch[k].ph, ph_pass[k],
                    loop_in[k].slew_limiting, pr.pfill, pr.pdrain);
            fdiff = loop_in[k].ref_period > loop_in[k].fb_period ?
                loop_in[k].ref_period - loop_in[k].fb_period :
                loop_in[k].fb_period - loop_in[k].ref_period;
            if (prof_chg)
                next_s.ch[k].fr = '{level: LV_EMPTY, locked: 1'b0};
            else if (loop_in[k].fd_valid)
                next_s.ch[k].fr = det_step(s.ch[k].fr,
                    fdiff <= {8'h00, pr.fthr}, 1'b0, pr.ffill, pr.fdrain);
            set[ST_PLOCK] = !s.ch[k].ph.locked & next_s.ch[k].ph.locked;
            set[ST_PUNLOCK] = s.ch[k].ph.locked & !next_s.ch[k].ph.locked;
            set[ST_FLOCK] = !s.ch[k].fr.locked & next_s.ch[k].fr.locked;
            set[ST_FUNLOCK] = s.ch[k].fr.locked & !next_s.ch[k].fr.locked;
            next_s.ch[k].latch = (s.ch[k].latch & ~clr[k]) | set;
            next_s.irq[k] = |(next_s.ch[k].latch & next_s.ch[k].mask);
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
            for (int k = 0; k < NPROF; k++)
                s.prof[k] <= '{pthr: THR_RST, pdrain: DRAIN_RST,
                    pfill: FILL_RST, fthr: THR_RST, fdrain: DRAIN_RST,
                    ffill: FILL_RST};
            for (int k = 0; k < 2; k++)
            begin
                s.ch[k].ph <= '{level: LV_EMPTY, locked: 1'b0};
                s.ch[k].fr <= '{level: LV_EMPTY, locked: 1'b0};
                s.ch[k].mask <= MASK_RST;
                s.ch[k].prof <= PROF_RST;
            end
            s.wst <= W_IDLE;
            s.rst <= R_IDLE;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end
        else if (core_en)
            s <= next_s;
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign irq_pending = s.irq;
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            phase_locked[k] = s.ch[k].ph.locked;
            freq_locked[k] = s.ch[k].fr.locked;
        end
    end

    // =========================================================
    // Checks on channel zero; freq_lock_c covers channel one
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    logic [7:0] fill0;
    assign fill0 = s.prof[s.ch[0].prof].pfill;

    sat_full_a: assert property (
        core_en && loop_in[0].pd_valid && !ph_restart[0] &&
        s.ch[0].ph.level == LV_FULL && ph_pass[0] && fill0 != 8'h00 &&
        !loop_in[0].slew_limiting |=> s.ch[0].ph.level == LV_FULL)
        else $error("phase level left full on a fill");
    low_unlock_a: assert property (
        s.ch[0].ph.level < LV_LOW |-> !s.ch[0].ph.locked)
        else $error("locked below low mark");
    high_lock_a: assert property (
        s.ch[0].fr.level > LV_HIGH |-> s.ch[0].fr.locked)
        else $error("unlocked above high mark");
    band_hold_a: assert property (
        core_en && !ph_restart[0] && next_s.ch[0].ph.level >= LV_LOW &&
        next_s.ch[0].ph.level <= LV_HIGH |=> $stable(s.ch[0].ph.locked))
        else $error("indication changed inside band");
    no_sample_a: assert property (
        core_en && !loop_in[0].pd_valid && !ph_restart[0]
        |=> $stable(s.ch[0].ph.level))
        else $error("level moved without a sample");
    fill_step_a: assert property (
        core_en && loop_in[0].pd_valid && !ph_restart[0] && ph_pass[0] &&
        !loop_in[0].slew_limiting && fill0 != 8'h00 &&
        s.ch[0].ph.level < 12'sh600
        |=> s.ch[0].ph.level == $past(s.ch[0].ph.level) + $past(fill0))
        else $error("fill not added on passing sample");
    slew_drain_a: assert property (
        core_en && loop_in[0].pd_valid && loop_in[0].slew_limiting &&
        !ph_restart[0] |=> s.ch[0].ph.level <= $past(s.ch[0].ph.level))
        else $error("fill seen while slew limiting");
    hold_unlock_a: assert property (
        core_en && loop_in[0].holdover
        |=> !s.ch[0].ph.locked && s.ch[0].ph.level == LV_EMPTY)
        else $error("phase not unlocked in holdover");
    lock_latch_a: assert property (
        !s.ch[0].ph.locked ##1 s.ch[0].ph.locked |-> s.ch[0].latch[ST_PLOCK])
        else $error("lock transition not latched");
    unlock_latch_a: assert property (
        s.ch[0].ph.locked ##1 !s.ch[0].ph.locked
        |-> s.ch[0].latch[ST_PUNLOCK])
        else $error("unlock transition not latched");

    lock_seen_c: cover property (!s.ch[0].ph.locked ##1 s.ch[0].ph.locked);
    freq_lock_c: cover property (!s.ch[1].fr.locked ##1 s.ch[1].fr.locked);
    irq_seen_c: cover property (s.irq[0] ##[1:20] !s.irq[0]);
    write_resp_c: cover property (s.bvalid && s_axi_bready);
endmodule : dpll_lock_detector

/* File: verif/loop_source_model.sv */
// Purpose: Drives phase and period samples into the lock detector.
// Assumes: Samples arrive on core_clk as one-cycle pulses.
// Notes: Sample data lines show inverted data between samples.
`timescale 1ns/100ps
module loop_source_model
    import lock_detect_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Samples toward the detector
    output loop_in_t [1:0] loop_in
);
    initial loop_in = '0;

    task automatic phase(input int ch, input logic [31:0] err);
        @(posedge core_clk);
        loop_in[ch].pd_valid <= 1'b1;
        loop_in[ch].pd_error <= err;
        @(posedge core_clk);
        loop_in[ch].pd_valid <= 1'b0;
        loop_in[ch].pd_error <= ~err;
    endtask : phase

    task automatic period(input int ch, input logic [31:0] rp, fp);
        @(posedge core_clk);
        loop_in[ch].fd_valid <= 1'b1;
        loop_in[ch].ref_period <= rp;
        loop_in[ch].fb_period <= fp;
        @(posedge core_clk);
        loop_in[ch].fd_valid <= 1'b0;
        loop_in[ch].ref_period <= ~rp;
        loop_in[ch].fb_period <= ~fp;
    endtask : period

    task automatic flags(input int ch, input logic slew, input logic hold);
        @(posedge core_clk);
        loop_in[ch].slew_limiting <= slew;
        loop_in[ch].holdover <= hold;
    endtask : flags
endmodule : loop_source_model

/* File: verif/dpll_lock_detector_tb.sv */
// Purpose: Self-checking bench for the dual-channel lock detector.
// Assumes: Register access over AXI4-Lite, one transfer at a time.
// Notes: Only channel zero carries loop traffic.
`timescale 1ns/100ps
module dpll_lock_detector_tb
    import lock_detect_pkg::*;
;
    logic core_clk = 1'b0, reset = 1'b1, core_en = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    loop_in_t [1:0] loop_in;
    logic [1:0] phase_locked, freq_locked, irq_pending;
    int n_mismatch = 0, checks_done = 0;

    dpll_lock_detector dut_u (.core_clk, .reset, .core_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .loop_in, .phase_locked, .freq_locked, .irq_pending);
    loop_source_model model_u (.core_clk, .loop_in);

    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    // ==============================================================
    // Bus and compare tasks
    task automatic check(input string what, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input string what, input logic [15:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(what, d, exp);
    endtask : rchk

    task automatic ph(input int n, input logic [31:0] e);
        repeat (n) model_u.phase(0, e);
        @(negedge core_clk);
    endtask : ph

    task automatic fq(input int n, input logic [31:0] rp, fp);
        repeat (n) model_u.period(0, rp, fp);
        @(negedge core_clk);
    endtask : fq

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        stop_test();
    end

    // ==============================================================
    // Test sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rchk("level", 16'h3110, 32'h0800_0800);
        rchk("mask", 16'h3108, 32'h0);
        rd(16'h4000, d, r);
        check("bad rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        check("bad rdata", d, 32'h0);
        for (int p = 0; p < NPROF; p++)
            wr(16'h0104 + 16'(p * 16), {16'h0, 8'(p), 8'(p + 8)});
        for (int p = 0; p < NPROF; p++)
            rchk("rate", 16'h0104 + 16'(p * 16),
                {16'h0, 8'(p), 8'(p + 8)});
        wr(16'h0170, 32'hFFFF_FFFF);
        rchk("pthr", 16'h0170, 32'h00FF_FFFF);
        wr(16'h0178, 32'hFFFF_FFFF);
        rchk("fthr", 16'h0178, 32'h00FF_FFFF);
        wr(16'h0100, 32'h0000_0064);
        wr(16'h0104, 32'h0000_40FF);
        ph(6, 32'h0000_0064);
        ph(6, 32'hFFFF_FF9C);
        check("lock12", 32'(phase_locked), 32'h0);
        ph(1, 32'hFFFF_FF9C);
        check("lock13", 32'(phase_locked), 32'h1);
        // The fifth sample arrives at full level and must not wrap.
        ph(5, 32'h0000_0064);
        rchk("sat", 16'h3110, 32'h0800_07FF);
        rchk("status", 16'h3100, 32'h11);
        ph(48, 32'h0000_0065);
        check("hold", 32'(phase_locked), 32'h1);
        ph(1, 32'hFFFF_FF9B);
        check("unlock", 32'(phase_locked), 32'h0);
        rchk("status", 16'h3100, 32'h03);
        model_u.flags(0, 1'b1, 1'b0);
        ph(1, 32'h0);
        rchk("slew", 16'h3110, 32'h0800_0B7F);
        wr(16'h0108, 32'h0000_03E8);
        wr(16'h010C, 32'h0000_10FF);
        fq(12, 32'h0000_1388, 32'h0000_1770);
        check("flock12", 32'(freq_locked), 32'h0);
        fq(1, 32'h0000_1770, 32'h0000_1388);
        check("flock13", 32'(freq_locked), 32'h1);
        model_u.flags(0, 1'b0, 1'b0);
        wr(16'h3104, 32'h1);
        rchk("cleared", 16'h3100, 32'h26);
        rchk("clr", 16'h3104, 32'h0);
        wr(16'h3108, 32'h2);
        @(negedge core_clk);
        check("irq", 32'(irq_pending), 32'h1);
        wr(16'h3104, 32'h2);
        @(negedge core_clk);
        check("irq clr", 32'(irq_pending), 32'h0);
        wr(16'h0104, 32'h0000_00FF);
        ph(9, 32'h0000_1388);
        check("drain0", 32'(phase_locked), 32'h1);
        rchk("level", 16'h3110, 32'h04F3_0476);
        // Holdover is sampled one edge after the model raises it.
        model_u.flags(0, 1'b0, 1'b1);
        repeat (2) @(negedge core_clk);
        check("holdover", 32'(phase_locked), 32'h0);
        model_u.flags(0, 1'b0, 1'b0);
        wr(16'h310C, 32'h1);
        @(negedge core_clk);
        check("prof chg", 32'(freq_locked), 32'h0);
        // Passing samples while the enable is low must leave levels alone.
        @(posedge core_clk);
        core_en <= 1'b0;
        ph(2, 32'h0);
        @(posedge core_clk);
        core_en <= 1'b1;
        rchk("level", 16'h3110, 32'h0800_0800);
        wr(16'h3100, 32'h0);
        check("ro bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
        rchk("status", 16'h3100, 32'h0F);
        rchk("ch1", 16'h3200, 32'h0);
        stop_test();
    end
endmodule : dpll_lock_detector_tb
